// ### swc_pkg.sv
package swc_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] SWC_ADDR_WAKE_EN = 8'h00;
	localparam logic [7:0] SWC_ADDR_OSC_CFG = 8'h04;
	localparam logic [7:0] SWC_ADDR_STATUS = 8'h08;

	// status field positions
	localparam int SWC_STAT_SETTLED = 0;
	localparam int SWC_STAT_ASLEEP = 1;
	localparam int SWC_STAT_SLEEP_ENTERED = 3;
	localparam int SWC_STAT_WDT_EXPIRY = 4;

	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [10:0] SWC_WAKE_EN_RST = 11'h000;
	localparam logic SWC_SLEEP_ENTERED_RST = 1'b1;
	localparam logic SWC_WDT_EXPIRY_RST = 1'b1;
	localparam logic [10:0] SWC_SETTLE_PERIODS = 11'h400;
	localparam logic [12:0] SWC_IRQ_VECTOR = 13'h0004;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SWC_MODE_LOW_POWER_CRYSTAL = 3'h0,
		SWC_MODE_STANDARD_CRYSTAL = 3'h1,
		SWC_MODE_HIGH_SPEED_CRYSTAL = 3'h2,
		SWC_MODE_EXTERNAL_CLOCK = 3'h3,
		SWC_MODE_RESISTOR_CAP_OSC = 3'h4,
		SWC_MODE_INTERNAL_SLOW_OSC = 3'h5
	} swc_osc_mode_t;

	localparam swc_osc_mode_t SWC_OSC_MODE_RST = SWC_MODE_RESISTOR_CAP_OSC;

	typedef enum logic [2:0] {
		SWC_ST_RUN = 3'b001,
		SWC_ST_SLEEP = 3'b010,
		SWC_ST_SETTLE = 3'b100
	} swc_state_t;

	typedef enum logic [1:0] {
		SWC_CAUSE_POR = 2'h0,
		SWC_CAUSE_MASTER_CLEAR_PIN = 2'h1,
		SWC_CAUSE_WDT = 2'h2,
		SWC_CAUSE_IRQ = 2'h3
	} swc_cause_t;

	// interrupt sources able to wake the device
	typedef struct packed {
		logic int_pin;
		logic portb_change;
		logic [8:0] periph;
	} swc_wake_src_t;

	// oscillator and monitor controls
	typedef struct packed {
		logic osc_drive_on;
		logic sys_clk_internal;
		logic monitor_en;
	} swc_clk_ctrl_t;

endpackage

// ### swc_sleep_wake_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module swc_sleep_wake_ctrl
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// core
	input wire logic sleep_op,
	input wire logic watchdog_clear_op,
	input wire logic global_irq_enable,
	output logic core_stall,
	output logic core_reset,
	output logic prefetch_next,
	output logic resume,
	output logic vector_take,
	output logic [12:0] vector_addr,
	output logic io_hold,
	// interrupt sources
	input wire swc_pkg::swc_wake_src_t irq_flags,
	input wire logic clocked_irq,
	output logic periph_irq,
	// reset pin and watchdog
	input wire logic master_clear_pin_n,
	input wire logic wdt_enabled,
	input wire logic wdt_expire,
	output logic wdt_clear,
	// oscillator
	input wire logic osc_tick,
	input wire logic pll_locked,
	output swc_pkg::swc_clk_ctrl_t clk_ctrl,
	output logic osc_restart_req
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic is_crystal(input swc_pkg::swc_osc_mode_t m);
		is_crystal = (m == swc_pkg::SWC_MODE_LOW_POWER_CRYSTAL) ||
			(m == swc_pkg::SWC_MODE_STANDARD_CRYSTAL) ||
			(m == swc_pkg::SWC_MODE_HIGH_SPEED_CRYSTAL);
	endfunction

	swc_pkg::swc_state_t state_q;
	swc_pkg::swc_state_t state_d;
	swc_pkg::swc_cause_t cause_q;
	swc_pkg::swc_cause_t cause_d;
	swc_pkg::swc_osc_mode_t mode_q;
	logic [10:0] wake_en_q;
	logic [10:0] settle_cnt_q;
	logic sleep_entered_q;
	logic wdt_expiry_q;
	logic settled_q;
	logic pend;
	logic wdt_wake;
	logic crystal;
	logic settle_done;
	logic take_sleep;
	logic sleep_nop;
	logic resume_d;
	logic vector_d;

	// enabled pending interrupt; the listed sources only
	assign pend = |(irq_flags & wake_en_q);
	assign wdt_wake = wdt_expire && wdt_enabled;
	assign crystal = is_crystal(mode_q);
	assign settle_done = !crystal || ((settle_cnt_q == swc_pkg::SWC_SETTLE_PERIODS) && pll_locked);

	// restart request straight from levels, no clock needed
	assign osc_restart_req = (state_q == swc_pkg::SWC_ST_SLEEP) &&
		(!master_clear_pin_n || wdt_wake || pend);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// next state and one-cycle events
	always_comb
	begin
		state_d = state_q;
		cause_d = cause_q;
		take_sleep = 1'b0;
		sleep_nop = 1'b0;
		resume_d = 1'b0;
		vector_d = 1'b0;
		case (state_q)
			swc_pkg::SWC_ST_RUN:
			begin
				if (sleep_op)
				begin
					if (pend && !global_irq_enable)
						sleep_nop = 1'b1;
					else
					begin
						take_sleep = 1'b1;
						state_d = swc_pkg::SWC_ST_SLEEP;
					end
				end
			end
			swc_pkg::SWC_ST_SLEEP:
			begin
				if (!master_clear_pin_n)
				begin
					state_d = swc_pkg::SWC_ST_SETTLE;
					cause_d = swc_pkg::SWC_CAUSE_MASTER_CLEAR_PIN;
				end
				else if (wdt_wake)
				begin
					state_d = swc_pkg::SWC_ST_SETTLE;
					cause_d = swc_pkg::SWC_CAUSE_WDT;
				end
				else if (pend)
				begin
					state_d = swc_pkg::SWC_ST_SETTLE;
					cause_d = swc_pkg::SWC_CAUSE_IRQ;
				end
			end
			swc_pkg::SWC_ST_SETTLE:
			begin
				if (settle_done)
				begin
					state_d = swc_pkg::SWC_ST_RUN;
					resume_d = (cause_q == swc_pkg::SWC_CAUSE_WDT) || (cause_q == swc_pkg::SWC_CAUSE_IRQ);
					vector_d = (cause_q == swc_pkg::SWC_CAUSE_IRQ) && global_irq_enable;
				end
			end
			default:
				state_d = swc_pkg::SWC_ST_RUN;
		endcase
	end

	// state and wake cause; power-up starts as a settle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= swc_pkg::SWC_ST_SETTLE;
			cause_q <= swc_pkg::SWC_CAUSE_POR;
		end
		else
		begin
			state_q <= state_d;
			cause_q <= cause_d;
		end
	end

	// oscillator settle counter in primary periods
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			settle_cnt_q <= 11'h000;
		else if (state_q != swc_pkg::SWC_ST_SETTLE)
			settle_cnt_q <= 11'h000;
		else if (crystal && osc_tick && (settle_cnt_q != swc_pkg::SWC_SETTLE_PERIODS))
			settle_cnt_q <= settle_cnt_q + 11'h001;
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	// sleep-entered flag
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			sleep_entered_q <= swc_pkg::SWC_SLEEP_ENTERED_RST;
		else if (take_sleep)
			sleep_entered_q <= 1'b0;
	end

	// watchdog-expiry flag
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			wdt_expiry_q <= swc_pkg::SWC_WDT_EXPIRY_RST;
		else if (take_sleep)
			wdt_expiry_q <= 1'b1;
		else if ((state_q == swc_pkg::SWC_ST_SLEEP) && (cause_d == swc_pkg::SWC_CAUSE_WDT) &&
			(state_d == swc_pkg::SWC_ST_SETTLE))
			wdt_expiry_q <= 1'b0;
	end

	// primary oscillator settled
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			settled_q <= 1'b0;
		else if (take_sleep)
			settled_q <= 1'b0;
		else if ((state_q == swc_pkg::SWC_ST_SETTLE) && settle_done)
			settled_q <= 1'b1;
	end

	// ----------------------------------------------------------------
	// core, watchdog and port controls
	// ----------------------------------------------------------------
	// one-cycle pulses toward core and watchdog
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wdt_clear <= 1'b0;
			prefetch_next <= 1'b0;
			resume <= 1'b0;
			vector_take <= 1'b0;
		end
		else
		begin
			wdt_clear <= take_sleep || watchdog_clear_op;
			prefetch_next <= take_sleep || sleep_nop;
			resume <= resume_d;
			vector_take <= vector_d;
		end
	end

	// interrupt vector address
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			vector_addr <= 13'h0000;
		else if (vector_d)
			vector_addr <= swc_pkg::SWC_IRQ_VECTOR;
	end

	// levels: stall, reset, port hold, clocked interrupt gate
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			core_stall <= 1'b0;
			core_reset <= 1'b0;
			io_hold <= 1'b0;
			periph_irq <= 1'b0;
		end
		else
		begin
			core_stall <= (state_d == swc_pkg::SWC_ST_SLEEP) || ((state_d == swc_pkg::SWC_ST_SETTLE) &&
				((cause_d == swc_pkg::SWC_CAUSE_WDT) || (cause_d == swc_pkg::SWC_CAUSE_IRQ)));
			core_reset <= !master_clear_pin_n;
			io_hold <= (state_d == swc_pkg::SWC_ST_SLEEP);
			periph_irq <= clocked_irq && (state_d == swc_pkg::SWC_ST_RUN);
		end
	end

	// oscillator driver, clock source and monitor enable
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			clk_ctrl <= '{osc_drive_on: 1'b1, sys_clk_internal: 1'b0, monitor_en: 1'b0};
		else
		begin
			clk_ctrl.osc_drive_on <= (state_d != swc_pkg::SWC_ST_SLEEP);
			clk_ctrl.sys_clk_internal <= (state_d == swc_pkg::SWC_ST_SETTLE) && crystal;
			clk_ctrl.monitor_en <= (state_d != swc_pkg::SWC_ST_SLEEP) &&
				!((state_d == swc_pkg::SWC_ST_SETTLE) && crystal);
		end
	end

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	// writable configuration
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wake_en_q <= swc_pkg::SWC_WAKE_EN_RST;
			mode_q <= swc_pkg::SWC_OSC_MODE_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == swc_pkg::SWC_ADDR_WAKE_EN)
				wake_en_q <= reg_wdata[10:0];
			else if (reg_addr == swc_pkg::SWC_ADDR_OSC_CFG)
				mode_q <= swc_pkg::swc_osc_mode_t'(reg_wdata[2:0]);
		end
	end

	// read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 16'h0000;
		else if (!reg_rd)
			reg_rdata <= 16'h0000;
		else if (reg_addr == swc_pkg::SWC_ADDR_WAKE_EN)
			reg_rdata <= {5'h00, wake_en_q};
		else if (reg_addr == swc_pkg::SWC_ADDR_OSC_CFG)
			reg_rdata <= {13'h0000, mode_q};
		else if (reg_addr == swc_pkg::SWC_ADDR_STATUS)
		begin
			reg_rdata <= 16'h0000;
			reg_rdata[swc_pkg::SWC_STAT_SETTLED] <= settled_q;
			reg_rdata[swc_pkg::SWC_STAT_ASLEEP] <= (state_q == swc_pkg::SWC_ST_SLEEP);
			reg_rdata[swc_pkg::SWC_STAT_SLEEP_ENTERED] <= sleep_entered_q;
			reg_rdata[swc_pkg::SWC_STAT_WDT_EXPIRY] <= wdt_expiry_q;
		end
		else
			reg_rdata <= 16'h0000;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	property p_sleep_effects;
		(state_q == swc_pkg::SWC_ST_RUN) && sleep_op && !(pend && !global_irq_enable)
			|=> !sleep_entered_q && wdt_expiry_q && wdt_clear && !clk_ctrl.osc_drive_on;
	endproperty
	a_sleep_effects: assert property (p_sleep_effects) else $error("sleep entry effects missing");

	property p_sleep_nop;
		(state_q == swc_pkg::SWC_ST_RUN) && sleep_op && pend && !global_irq_enable
			|=> $stable(sleep_entered_q) && $stable(wdt_expiry_q) && (state_q == swc_pkg::SWC_ST_RUN) && prefetch_next;
	endproperty
	a_sleep_nop: assert property (p_sleep_nop) else $error("sleep not treated as no-op");

	property p_only_sleep_op;
		(state_q == swc_pkg::SWC_ST_RUN) && !sleep_op |=> state_q != swc_pkg::SWC_ST_SLEEP;
	endproperty
	a_only_sleep_op: assert property (p_only_sleep_op) else $error("sleep entered without instruction");

	property p_hold_in_sleep;
		(state_q == swc_pkg::SWC_ST_SLEEP) |-> io_hold && !clk_ctrl.osc_drive_on && !periph_irq;
	endproperty
	a_hold_in_sleep: assert property (p_hold_in_sleep) else $error("ports or clocks active in sleep");

	property p_wdt_wake;
		(state_q == swc_pkg::SWC_ST_SLEEP) && master_clear_pin_n && wdt_wake
			|=> !wdt_expiry_q && (state_q == swc_pkg::SWC_ST_SETTLE);
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake did not clear flag");

	property p_master_clear_pin_reset;
		(state_q == swc_pkg::SWC_ST_SLEEP) && !master_clear_pin_n
			|=> core_reset && (cause_q == swc_pkg::SWC_CAUSE_MASTER_CLEAR_PIN);
	endproperty
	a_master_clear_pin_reset: assert property (p_master_clear_pin_reset) else $error("master clear did not reset");

	property p_irq_wake;
		(state_q == swc_pkg::SWC_ST_SLEEP) && master_clear_pin_n && !wdt_wake && pend && !global_irq_enable
			|=> (state_q == swc_pkg::SWC_ST_SETTLE) && (cause_q == swc_pkg::SWC_CAUSE_IRQ);
	endproperty
	a_irq_wake: assert property (p_irq_wake) else $error("enabled interrupt failed to wake");

	property p_restart_req;
		(state_q == swc_pkg::SWC_ST_SLEEP) && pend |-> osc_restart_req;
	endproperty
	a_restart_req: assert property (p_restart_req) else $error("no restart request on wake");

	property p_rc_no_delay;
		(state_q == swc_pkg::SWC_ST_SETTLE) && !crystal |=> (state_q == swc_pkg::SWC_ST_RUN);
	endproperty
	a_rc_no_delay: assert property (p_rc_no_delay) else $error("settle delay in non-crystal mode");

	property p_crystal_wait;
		(state_q == swc_pkg::SWC_ST_SETTLE) && crystal && (settle_cnt_q != swc_pkg::SWC_SETTLE_PERIODS)
			|=> (state_q == swc_pkg::SWC_ST_SETTLE) && !clk_ctrl.monitor_en && clk_ctrl.sys_clk_internal;
	endproperty
	a_crystal_wait: assert property (p_crystal_wait) else $error("crystal settle cut short");

	property p_vector;
		vector_take |-> resume && (vector_addr == swc_pkg::SWC_IRQ_VECTOR) && $past(global_irq_enable);
	endproperty
	a_vector: assert property (p_vector) else $error("vector without irq resume");

	c_irq_wake: cover property ((state_q == swc_pkg::SWC_ST_SLEEP) ##1 (state_q == swc_pkg::SWC_ST_SETTLE) ##[1:20] vector_take);
	c_wdt_wake: cover property ((state_q == swc_pkg::SWC_ST_SLEEP) && wdt_wake ##[1:20] resume);
	c_sleep_nop: cover property (sleep_nop);
	c_master_clear_pin_wake: cover property ((state_q == swc_pkg::SWC_ST_SLEEP) && !master_clear_pin_n);

endmodule

`default_nettype wire

// ### swc_osc_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// primary oscillator and pll stand-in
// ----------------------------------------------------------------
module swc_osc_model
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// oscillator control
	input wire logic drive_on,
	// oscillator status
	output logic osc_tick,
	output logic pll_locked
);
	logic [3:0] lock_q;

	// ticks only while the driver runs; lock is lost when it stops
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			osc_tick <= 1'b0;
			lock_q <= 4'h0;
		end
		else
		begin
			osc_tick <= drive_on;
			if (!drive_on)
				lock_q <= 4'h0;
			else if (lock_q != 4'hf)
				lock_q <= lock_q + 4'h1;
		end
	end

	// pll timer expires some ticks after the restart
	assign pll_locked = (lock_q == 4'hf);
endmodule

`default_nettype wire

// ### swc_sleep_wake_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none

module swc_sleep_wake_ctrl_tb;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic [15:0] d;
	logic [10:0] en;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sleep_op = 1'b0;
	logic watchdog_clear_op = 1'b0;
	logic global_irq_enable = 1'b0;
	logic clocked_irq = 1'b0;
	logic master_clear_pin_n = 1'b1;
	logic wdt_enabled = 1'b0;
	logic wdt_expire = 1'b0;
	swc_pkg::swc_wake_src_t irq_flags = 11'h000;
	logic core_stall, core_reset, prefetch_next, resume, vector_take, io_hold;
	logic periph_irq, wdt_clear, osc_tick, pll_locked, osc_restart_req;
	logic [12:0] vector_addr;
	swc_pkg::swc_clk_ctrl_t clk_ctrl;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc = 0;
	int n;
	logic [31:0] seed = 32'hc71c;

	swc_sleep_wake_ctrl uut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_op(sleep_op),
		.watchdog_clear_op(watchdog_clear_op), .global_irq_enable(global_irq_enable), .core_stall(core_stall),
		.core_reset(core_reset), .prefetch_next(prefetch_next), .resume(resume), .vector_take(vector_take),
		.vector_addr(vector_addr), .io_hold(io_hold), .irq_flags(irq_flags), .clocked_irq(clocked_irq),
		.periph_irq(periph_irq), .master_clear_pin_n(master_clear_pin_n), .wdt_enabled(wdt_enabled),
		.wdt_expire(wdt_expire), .wdt_clear(wdt_clear), .osc_tick(osc_tick), .pll_locked(pll_locked),
		.clk_ctrl(clk_ctrl), .osc_restart_req(osc_restart_req));

	swc_osc_model osc (.core_clk(core_clk), .rstn(rstn), .drive_on(clk_ctrl.osc_drive_on),
		.osc_tick(osc_tick), .pll_locked(pll_locked));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	always #25 core_clk = ~core_clk;

	// hang guard
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail = n_fail + 1;
			test_done();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// wake expected from enabled and raised sources
	function automatic logic wakes(input logic [10:0] e, input logic [10:0] f);
		return |(e & f);
	endfunction

	task automatic chk_bit(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	task automatic do_sleep();
		@(posedge core_clk);
		sleep_op <= 1'b1;
		@(posedge core_clk);
		sleep_op <= 1'b0;
		#1;
	endtask

	task automatic wait_resume(output int k);
		k = 0;
		while (resume !== 1'b1 && k < 3000)
		begin
			@(posedge core_clk);
			#1;
			k++;
		end
	endtask

	task automatic endt(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge core_clk);
		// release between edges so no assertion attempt straddles it
		@(negedge core_clk);
		rstn <= 1'b1;
		tick(2);
		rd(swc_pkg::SWC_ADDR_STATUS, d);
		chk_bit("sleep_entered", 1'b1, d[3]);
		chk_bit("wdt_expiry", 1'b1, d[4]);
		chk_bit("monitor_en", 1'b1, clk_ctrl.monitor_en);
		rd(8'h0c, d);
		chk_word("unmapped", 16'h0000, d);
		// random source activity without the instruction
		repeat (8)
		begin
			seed = xs(seed);
			irq_flags <= seed[10:0];
			clocked_irq <= 1'b1;
			tick(1);
			chk_bit("io_hold", 1'b0, io_hold);
		end
		irq_flags <= 11'h000;
		chk_bit("periph_irq_run", 1'b1, periph_irq);
		endt("run");
		// interrupt wake, rc mode, global enable set
		seed = xs(seed);
		en = {2'b10, seed[8:0]};
		wr(swc_pkg::SWC_ADDR_WAKE_EN, {5'h00, en});
		rd(swc_pkg::SWC_ADDR_WAKE_EN, d);
		chk_word("wake_en", {5'h00, en}, d);
		global_irq_enable <= 1'b1;
		@(posedge core_clk);
		watchdog_clear_op <= 1'b1;
		tick(1);
		chk_bit("wdt_clear_op", 1'b1, wdt_clear);
		watchdog_clear_op <= 1'b0;
		tick(1);
		chk_bit("wdt_clear_end", 1'b0, wdt_clear);
		do_sleep();
		chk_bit("prefetch", 1'b1, prefetch_next);
		chk_bit("wdt_clear", 1'b1, wdt_clear);
		chk_bit("osc_drive", 1'b0, clk_ctrl.osc_drive_on);
		chk_bit("io_hold", 1'b1, io_hold);
		chk_bit("stall_sleep", 1'b1, core_stall);
		rd(swc_pkg::SWC_ADDR_STATUS, d);
		chk_bit("sleep_entered", 1'b0, d[3]);
		chk_bit("wdt_expiry", 1'b1, d[4]);
		chk_bit("asleep", 1'b1, d[1]);
		chk_bit("settled_sleep", 1'b0, d[0]);
		chk_bit("periph_irq_sleep", 1'b0, periph_irq);
		clocked_irq <= 1'b0;
		irq_flags <= 11'h200;
		tick(4);
		chk_bit("disabled_src", !wakes(en, 11'h200), io_hold);
		irq_flags <= 11'h400;
		// request is combinational, look before the wake edge
		#1;
		chk_bit("restart_req", 1'b1, osc_restart_req);
		wait_resume(n);
		irq_flags <= 11'h000;
		chk_bit("rc_no_delay", 1'b1, n <= 3);
		chk_bit("vector_take", 1'b1, vector_take);
		chk_word("vector", {3'h0, swc_pkg::SWC_IRQ_VECTOR}, {3'h0, vector_addr});
		endt("irq_wake");
		// watchdog wake continues without vectoring
		wdt_enabled <= 1'b1;
		do_sleep();
		tick(2);
		wdt_expire <= 1'b1;
		tick(1);
		wdt_expire <= 1'b0;
		wait_resume(n);
		chk_bit("wdt_resume", 1'b1, resume);
		chk_bit("wdt_no_vector", 1'b0, vector_take);
		wdt_enabled <= 1'b0;
		rd(swc_pkg::SWC_ADDR_STATUS, d);
		chk_bit("wdt_expiry", 1'b0, d[4]);
		endt("wdt_wake");
		// pending source with global enable clear
		global_irq_enable <= 1'b0;
		irq_flags <= 11'h400;
		do_sleep();
		chk_bit("noop_prefetch", 1'b1, prefetch_next);
		chk_bit("noop_wdt", 1'b0, wdt_clear);
		chk_bit("noop_io", 1'b0, io_hold);
		rd(swc_pkg::SWC_ADDR_STATUS, d);
		chk_bit("noop_expiry", 1'b0, d[4]);
		irq_flags <= 11'h000;
		endt("noop");
		// crystal wake waits the settle count on internal clock
		wr(swc_pkg::SWC_ADDR_OSC_CFG, {13'h0000, swc_pkg::SWC_MODE_STANDARD_CRYSTAL});
		do_sleep();
		tick(3);
		irq_flags <= 11'h400;
		tick(10);
		chk_bit("internal_clk", 1'b1, clk_ctrl.sys_clk_internal);
		chk_bit("monitor_off", 1'b0, clk_ctrl.monitor_en);
		wait_resume(n);
		irq_flags <= 11'h000;
		chk_bit("crystal_resume", 1'b1, resume);
		chk_bit("settle_long", 1'b1, (n >= int'(swc_pkg::SWC_SETTLE_PERIODS) - 16) &&
			(n <= int'(swc_pkg::SWC_SETTLE_PERIODS) + 16));
		chk_bit("inline", 1'b0, vector_take);
		rd(swc_pkg::SWC_ADDR_STATUS, d);
		chk_bit("settled", 1'b1, d[0]);
		chk_bit("monitor_back", 1'b1, clk_ctrl.monitor_en);
		endt("crystal");
		// master clear in sleep resets without resume, external clock mode
		wr(swc_pkg::SWC_ADDR_OSC_CFG, {13'h0000, swc_pkg::SWC_MODE_EXTERNAL_CLOCK});
		rd(swc_pkg::SWC_ADDR_OSC_CFG, d);
		chk_word("osc_cfg", {13'h0000, swc_pkg::SWC_MODE_EXTERNAL_CLOCK}, d);
		do_sleep();
		master_clear_pin_n <= 1'b0;
		tick(3);
		chk_bit("core_reset", 1'b1, core_reset);
		chk_bit("no_resume", 1'b0, resume);
		master_clear_pin_n <= 1'b1;
		tick(4);
		chk_bit("stall_off", 1'b0, core_stall);
		chk_bit("monitor_ext", 1'b1, clk_ctrl.monitor_en);
		endt("master_clear_pin");
		test_done();
	end
endmodule

`default_nettype wire
